// file: hdl/adcsr_map.svh
// constants of the serial readout port: word size, counters, timing
// assumes the includer runs on the 200 MHz system clock
`ifndef ADCSR_MAP_SVH
`define ADCSR_MAP_SVH

// ============================================================
// word and bit counter
`define ADCSR_WORD_BITS      16
`define ADCSR_BITCNT_W       5
`define ADCSR_BITCNT_FULL    5'h10
`define ADCSR_BITCNT_RST     5'h00
`define ADCSR_WORD_RST       16'h0000

// ============================================================
// timing: system clock and conversion length
`define ADCSR_CLK_PERIOD_NS  5
`define ADCSR_CONV_TIME_NS   1500
`define ADCSR_CONV_CYCLES    ((`ADCSR_CONV_TIME_NS + `ADCSR_CLK_PERIOD_NS - 1) / `ADCSR_CLK_PERIOD_NS)
`define ADCSR_TIMER_W        9
`define ADCSR_TIMER_RST      9'h000
`define ADCSR_TIMER_LOAD     9'h12B

// ============================================================
// synchroniser lanes in the system domain
`define ADCSR_PIN_LANES      7
`define ADCSR_LANE_CNVN      0
`define ADCSR_LANE_SELN      1
`define ADCSR_LANE_RDN       2
`define ADCSR_LANE_EXT       3
`define ADCSR_LANE_SER       4
`define ADCSR_LANE_STARTED   5
`define ADCSR_LANE_DONE      6

`endif

// file: hdl/adcsr_pkg.sv
// types shared by the serial readout port
// assumes adcsr_map.svh defines the word width
`include "adcsr_map.svh"

package adcsr_pkg;

  // ============================================================
  // conversion sequencer
  typedef enum logic [0:0]
  {
    ADCSR_IDLE = 1'b0,
    ADCSR_CONV = 1'b1
  } adcsr_state_t;

  typedef logic [`ADCSR_WORD_BITS-1:0] adcsr_word_t;

endpackage

// file: hdl/adcsr_link_if.sv
// carrier between the system-domain core and the serial-clock shifter
// assumes word/chainOk/frameIdle come from system-clock flops
`timescale 1ns/1ps

interface adcsr_link_if;
  adcsr_pkg::adcsr_word_t word;
  logic                   chainOk;
  logic                   frameIdle;
  logic                   started;
  logic                   done;

  modport core
  (
    output word,
    output chainOk,
    output frameIdle,
    input  started,
    input  done
  );

  modport link
  (
    input  word,
    input  chainOk,
    input  frameIdle,
    output started,
    output done
  );
endinterface

// file: hdl/adcsr_sync2.sv
// two-flop level synchroniser, one lane per bit
// assumes each lane is a slow level from another domain
`timescale 1ns/1ps

module adcsr_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta;

  // ============================================================
  // lanes: first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_lane
      always_ff @(posedge clk)
      begin
        meta[i] <= din[i];
        dout[i] <= meta[i];
      end
    end
  endgenerate

endmodule

// file: hdl/adcsr_link_shifter.sv
// serial-clock side: bit counter, result shifter, chain pass-through
// assumes frameIdle is a glitch-free flop that holds the logic cleared
`include "adcsr_map.svh"
`timescale 1ns/1ps

module adcsr_link_shifter (
  input  wire logic sclk,
  input  wire logic chainSerialIn,
  adcsr_link_if.link lnk,
  output logic      serialOut
);

  logic [`ADCSR_BITCNT_W-1:0] bitCnt;
  logic [`ADCSR_BITCNT_W-1:0] next_bitCnt;
  logic                       next_serialOut;
  logic                       next_started;
  logic                       next_done;
  logic [`ADCSR_WORD_BITS-1:0] chainHist;
  logic [`ADCSR_WORD_BITS-1:0] next_chainHist;
  logic                       chainOkSync;
  logic [3:0]                 bitIdx;

  // chain enable only settles after two edges; first 16 edges cover it
  adcsr_sync2 #(.W(1)) u_chainSync
  (
    .clk  (sclk),
    .din  (lnk.chainOk),
    .dout (chainOkSync)
  );

  // ============================================================
  // next values
  assign bitIdx = ~bitCnt[3:0];
  assign next_chainHist = {chainHist[`ADCSR_WORD_BITS-2:0], chainSerialIn};

  always_comb
  begin
    next_bitCnt    = bitCnt;
    next_serialOut = 1'b0;
    next_started   = 1'b1;
    next_done      = lnk.done;
    if (bitCnt != `ADCSR_BITCNT_FULL)
    begin
      next_serialOut = lnk.word[bitIdx];
      next_bitCnt    = bitCnt + 5'h01;
      next_done      = (bitCnt == (`ADCSR_BITCNT_FULL - 5'h01));
    end
    else if (chainOkSync)
    begin
      next_serialOut = chainHist[`ADCSR_WORD_BITS-1];
    end
  end

  // ============================================================
  // registers: cleared while deselected, so sclk is ignored then
  always_ff @(posedge sclk or posedge lnk.frameIdle)
  begin
    if (lnk.frameIdle)
    begin
      bitCnt      <= `ADCSR_BITCNT_RST;
      serialOut   <= 1'b0;
      lnk.started <= 1'b0;
      lnk.done    <= 1'b0;
    end
    else
    begin
      bitCnt      <= next_bitCnt;
      serialOut   <= next_serialOut;
      lnk.started <= next_started;
      lnk.done    <= next_done;
    end
  end

  // upstream bits caught on the edge opposite the shift edge;
  // a word-long delay puts the upstream MSB right after our LSB
  always_ff @(negedge sclk or posedge lnk.frameIdle)
  begin
    if (lnk.frameIdle)
      chainHist <= `ADCSR_WORD_RST;
    else
      chainHist <= next_chainHist;
  end

endmodule

// file: hdl/adcsr_serial_port.sv
// slave serial readout port of a 16-bit converter
// assumes the host drives sclk, selectN and readEnN; the core result
// arrives on coreResult and is stable when the conversion time ends
`include "adcsr_map.svh"
`timescale 1ns/1ps

module adcsr_serial_port (
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  input  wire logic                          sclk,
  input  wire logic                          convertStartN,
  input  wire logic                          selectN,
  input  wire logic                          readEnN,
  input  wire logic                          clockSourceSelect,
  input  wire logic                          portStyleSelect,
  input  wire logic                          chainSerialIn,
  input  wire logic [`ADCSR_WORD_BITS-1:0]   coreResult,
  output logic                               busy,
  output logic                               serialResultOut,
  output logic                               serialResultOutOeN,
  output logic                               readOverrunPulse
);

  // ============================================================
  // declarations
  adcsr_link_if lnk ();

  logic [`ADCSR_PIN_LANES-1:0] pinRaw;
  logic [`ADCSR_PIN_LANES-1:0] pinSync;

  adcsr_pkg::adcsr_state_t     state;
  adcsr_pkg::adcsr_state_t     next_state;
  logic [`ADCSR_TIMER_W-1:0]   timer;
  logic [`ADCSR_TIMER_W-1:0]   next_timer;
  logic                        next_busy;
  logic                        cnvPrev;
  logic                        cnvFall;
  logic                        convEnd;

  adcsr_pkg::adcsr_word_t      lastResult;
  adcsr_pkg::adcsr_word_t      next_lastResult;
  logic                        next_overrun;

  logic                        frameIdle;
  logic                        next_frameIdle;
  logic                        chainOk;
  logic                        next_chainOk;
  logic                        readPending;
  logic                        frameStarted;
  logic                        next_frameStarted;
  logic                        frameDone;
  logic                        next_frameDone;
  logic                        frameInConv;
  logic                        next_frameInConv;
  adcsr_pkg::adcsr_word_t      linkWord;
  adcsr_pkg::adcsr_word_t      next_linkWord;

  // ============================================================
  // pin synchronisers
  assign pinRaw[`ADCSR_LANE_CNVN]    = convertStartN;
  assign pinRaw[`ADCSR_LANE_SELN]    = selectN;
  assign pinRaw[`ADCSR_LANE_RDN]     = readEnN;
  assign pinRaw[`ADCSR_LANE_EXT]     = clockSourceSelect;
  assign pinRaw[`ADCSR_LANE_SER]     = portStyleSelect;
  assign pinRaw[`ADCSR_LANE_STARTED] = lnk.started;
  assign pinRaw[`ADCSR_LANE_DONE]    = lnk.done;

  adcsr_sync2 #(.W(`ADCSR_PIN_LANES)) u_pinSync
  (
    .clk  (clk),
    .din  (pinRaw),
    .dout (pinSync)
  );

  // ============================================================
  // conversion sequencer
  // a running conversion cannot be restarted; extra falls are dropped
  assign cnvFall = cnvPrev & ~pinSync[`ADCSR_LANE_CNVN];
  assign convEnd = (state == adcsr_pkg::ADCSR_CONV) && (timer == `ADCSR_TIMER_RST);

  always_comb
  begin
    next_state = state;
    next_timer = timer;
    next_busy  = busy;
    case (state)
      adcsr_pkg::ADCSR_IDLE:
      begin
        if (cnvFall)
        begin
          next_state = adcsr_pkg::ADCSR_CONV;
          next_timer = `ADCSR_TIMER_LOAD;
          next_busy  = 1'b1;
        end
      end
      adcsr_pkg::ADCSR_CONV:
      begin
        if (convEnd)
        begin
          next_state = adcsr_pkg::ADCSR_IDLE;
          next_busy  = 1'b0;
        end
        else
        begin
          next_timer = timer - 9'h001;
        end
      end
      default:
      begin
        next_state = adcsr_pkg::ADCSR_IDLE;
        next_busy  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state   <= adcsr_pkg::ADCSR_IDLE;
      timer   <= `ADCSR_TIMER_RST;
      busy    <= 1'b0;
      cnvPrev <= 1'b1;
    end
    else
    begin
      state   <= next_state;
      timer   <= next_timer;
      busy    <= next_busy;
      cnvPrev <= pinSync[`ADCSR_LANE_CNVN];
    end
  end

  // ============================================================
  // link status
  // reset flops hide the unreset sync lanes right after reset
  always_comb
  begin
    next_frameStarted = pinSync[`ADCSR_LANE_STARTED];
    next_frameDone    = pinSync[`ADCSR_LANE_DONE];
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      frameStarted <= 1'b0;
      frameDone    <= 1'b0;
    end
    else
    begin
      frameStarted <= next_frameStarted;
      frameDone    <= next_frameDone;
    end
  end

  assign readPending = frameStarted & ~frameDone;

  // ============================================================
  // read mode of the open frame
  // latched at frame open: a read-after frame left open into the
  // next conversion is not a cut-off read-during transfer
  always_comb
  begin
    next_frameInConv = frameInConv;
    if (frameIdle)
    begin
      next_frameInConv = busy;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      frameInConv <= 1'b0;
    end
    else
    begin
      frameInConv <= next_frameInConv;
    end
  end

  // ============================================================
  // result holding and overrun
  // the word only moves at conversion end, so during a conversion
  // the shifter reads the previous result

  always_comb
  begin
    next_lastResult = lastResult;
    next_overrun    = 1'b0;
    if (convEnd)
    begin
      next_lastResult = coreResult;
      next_overrun    = readPending & ~frameIdle & frameInConv;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      lastResult       <= `ADCSR_WORD_RST;
      readOverrunPulse <= 1'b0;
    end
    else
    begin
      lastResult       <= next_lastResult;
      readOverrunPulse <= next_overrun;
    end
  end

  // ============================================================
  // frame gating toward the link
  // gating from flops keeps the shifter's clear free of glitches,
  // at the price of about three clk cycles before the first edge
  always_comb
  begin
    next_frameIdle = pinSync[`ADCSR_LANE_SELN]
                   | pinSync[`ADCSR_LANE_RDN]
                   | ~pinSync[`ADCSR_LANE_EXT]
                   | ~pinSync[`ADCSR_LANE_SER];
    // chain mode fixed at frame open, so it cannot flip mid-word
    next_chainOk   = chainOk;
    if (frameIdle)
    begin
      next_chainOk = ~busy & pinSync[`ADCSR_LANE_EXT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      frameIdle          <= 1'b1;
      chainOk            <= 1'b0;
      serialResultOutOeN <= 1'b1;
    end
    else
    begin
      frameIdle          <= next_frameIdle;
      chainOk            <= next_chainOk;
      serialResultOutOeN <= next_frameIdle;
    end
  end

  // ============================================================
  // word handed to the shifter
  // frozen while a frame is open, so the sclk side never sees it
  // move; a read cut off by conversion end keeps the old word
  always_comb
  begin
    next_linkWord = linkWord;
    if (frameIdle)
    begin
      next_linkWord = next_lastResult;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      linkWord <= `ADCSR_WORD_RST;
    end
    else
    begin
      linkWord <= next_linkWord;
    end
  end

  assign lnk.word      = linkWord;
  assign lnk.chainOk   = chainOk;
  assign lnk.frameIdle = frameIdle;

  // ============================================================
  // serial-clock shifter
  // no free-run assumption: each frame is cleared by frameIdle, so a
  // gated clock idling high or low starts from the same state
  adcsr_link_shifter u_shifter
  (
    .sclk          (sclk),
    .chainSerialIn (chainSerialIn),
    .lnk           (lnk.link),
    .serialOut     (serialResultOut)
  );

endmodule

// file: verif/adcsr_serial_port_sva.sv
// assertions on the ports of the serial readout port
// assumes the clk domain only; link side judged by the bench
`include "adcsr_map.svh"
`timescale 1ns/1ps

module adcsr_serial_port_sva (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic convertStartN,
  input wire logic selectN,
  input wire logic readEnN,
  input wire logic clockSourceSelect,
  input wire logic portStyleSelect,
  input wire logic busy,
  input wire logic serialResultOut,
  input wire logic serialResultOutOeN,
  input wire logic readOverrunPulse
);
  // ==========
  // busy length, held in the cycle busy falls
  localparam int CONV = `ADCSR_CONV_CYCLES;
  int   busyLen;
  int   next_busyLen;
  logic live;
  assign live = !selectN && !readEnN && clockSourceSelect && portStyleSelect;
  always_comb next_busyLen = busy ? busyLen + 1 : 0;
  always_ff @(posedge clk) busyLen <= sys_rst ? 0 : next_busyLen;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_busy_start: assert property ($fell(convertStartN) && !busy |-> ##[2:4] busy)
    else $error("busy missing after start");
  chk_busy_width: assert property ($fell(busy) |-> busyLen == CONV)
    else $error("busy width wrong");
  chk_busy_cause: assert property ($rose(busy) |-> $past(convertStartN, 2) == 1'b0)
    else $error("busy rose without start");
  chk_oe_release: assert property ((selectN || readEnN) [*6] |-> serialResultOutOeN)
    else $error("output driven while deselected");
  chk_oe_drive: assert property (live [*6] |-> !serialResultOutOeN)
    else $error("output not driven in frame");
  chk_port_off: assert property ((!clockSourceSelect || !portStyleSelect) [*6] |-> serialResultOutOeN)
    else $error("output driven with port off");
  chk_out_quiet: assert property (serialResultOutOeN [*4] |-> !serialResultOut)
    else $error("data left on idle output");
  chk_ovr_edge: assert property (readOverrunPulse |-> $fell(busy))
    else $error("overrun away from conversion end");
  chk_ovr_once: assert property (readOverrunPulse |=> !readOverrunPulse)
    else $error("overrun wider than one cycle");
  chk_ovr_frame: assert property (readOverrunPulse |-> $past(serialResultOutOeN) == 1'b0)
    else $error("overrun without open frame");
endmodule

bind adcsr_serial_port adcsr_serial_port_sva chk (
  .clk, .sys_rst, .convertStartN, .selectN, .readEnN, .clockSourceSelect,
  .portStyleSelect, .busy, .serialResultOut, .serialResultOutOeN, .readOverrunPulse
);

// file: verif/adcsr_host_model.sv
// host serial controller with a gated clock, 125 ns period
// assumes sdoWire already resolves the released output
`timescale 1ns/1ps

module adcsr_host_model (
  output logic        sclk,
  output logic        selectN,
  output logic        readEnN,
  output logic        chainSerialIn,
  input  wire logic   sdoWire
);
  logic [63:0] cap;

  initial
  begin
    sclk = 1'b0;
    selectN = 1'b1;
    readEnN = 1'b1;
    chainSerialIn = 1'b0;
  end

  // ==========
  // one frame: rising edge shifts, falling edge samples
  task automatic xfer(input int n, input logic idleHi, input logic [63:0] chain);
    cap = '0;
    sclk = idleHi;
    #($urandom_range(20, 80));
    selectN = 1'b0;
    readEnN = 1'b0;
    #100;
    if (idleHi)
      sclk = 1'b0;
    #62.5;
    for (int k = 0; k < n; k++)
    begin
      sclk = 1'b1;
      chainSerialIn = chain[k];
      #62.5;
      cap[k] = sdoWire;
      sclk = 1'b0;
      #62.5;
    end
    sclk = idleHi;
    #62.5;
    selectN = 1'b1;
    readEnN = 1'b1;
  endtask

  // edges while deselected, must be ignored
  task automatic stray(input int n);
    repeat (n)
    begin
      sclk = ~sclk;
      #62.5;
    end
  endtask
endmodule

// file: verif/adc_slave_serial_readout_tb_top.sv
// self-checking bench of the serial readout port
// assumes the design, checker and host model compile first
`timescale 1ns/1ps

module adc_slave_serial_readout_tb_top;
  logic clk = 1'b0, sys_rst = 1'b1, convertStartN = 1'b1;
  logic clockSourceSelect = 1'b1, portStyleSelect = 1'b1, lastSdo = 1'b0, oeSeen;
  logic busy, serialResultOut, serialResultOutOeN, readOverrunPulse;
  logic sclk, selectN, readEnN, chainSerialIn, sdoWire;
  int   num_errors, checks, ovCnt;
  adcsr_pkg::adcsr_word_t coreResult = '0;

  always #2.5 clk = ~clk;
  // released line reads as the inverse of its last level
  always @(posedge clk) if (serialResultOutOeN === 1'b0) lastSdo <= serialResultOut;
  always @(posedge clk) if (serialResultOutOeN === 1'b0) oeSeen <= 1'b1;
  always @(posedge clk) if (readOverrunPulse === 1'b1) ovCnt++;
  assign sdoWire = serialResultOutOeN ? ~lastSdo : serialResultOut;

  adcsr_serial_port dut (.clk, .sys_rst, .sclk, .convertStartN, .selectN, .readEnN,
    .clockSourceSelect, .portStyleSelect, .chainSerialIn, .coreResult, .busy,
    .serialResultOut, .serialResultOutOeN, .readOverrunPulse);
  adcsr_host_model host (.sclk, .selectN, .readEnN, .chainSerialIn, .sdoWire);

  // ==========
  // helpers
  function automatic logic [63:0] expect_bits(adcsr_pkg::adcsr_word_t w, logic [63:0] ch, logic on, int n);
    logic [63:0] e;
    e = '0;
    for (int k = 1; k <= n; k++)
      e[k-1] = (k <= 16) ? w[16-k] : (on & ch[k-17]);
    return e;
  endfunction

  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic convert(input adcsr_pkg::adcsr_word_t w);
    @(posedge clk);
    #1 coreResult = w;
    convertStartN = 1'b0;
    repeat (10) @(posedge clk);
    #1 convertStartN = 1'b1;
  endtask

  task automatic wait_idle;
    for (int i = 0; i < 400 && busy !== 1'b0; i++)
      @(negedge clk);
    check("busy end", 1'b0, busy);
    @(posedge clk);
    #1;
  endtask

  task automatic results;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ==========
  // tests
  initial
  begin
    adcsr_pkg::adcsr_word_t w;
    adcsr_pkg::adcsr_word_t prev;
    logic [63:0] ch;
    int n;
    int seen;
    void'($urandom(32'hC569));
    repeat (2) @(posedge clk);
    #1 sys_rst = 1'b0;
    check("busy", 1'b0, busy);
    check("oe", 1'b1, serialResultOutOeN);
    for (int m = 0; m < 2; m++)
    begin
      @(posedge clk);
      #1 clockSourceSelect = m[0];
      portStyleSelect = !m[0];
      oeSeen = 1'b0;
      host.xfer(4, 1'b0, '0);
      check("oe off", 1'b0, oeSeen);
    end
    @(posedge clk);
    #1 clockSourceSelect = 1'b1;
    portStyleSelect = 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      w = (i == 0) ? 16'h8001 : (i == 1) ? 16'h7FFE : 16'($urandom);
      ch = {$urandom, $urandom};
      n = (i < 3) ? 32 : 16 + i;
      convert(w);
      wait_idle();
      host.stray(3);
      host.xfer(8, i[0], ch);
      check("byte", expect_bits(w, ch, 1'b1, 8), host.cap);
      host.xfer(n, i[1], ch);
      check("chain", expect_bits(w, ch, 1'b1, n), host.cap);
    end
    prev = w;
    w = 16'($urandom);
    seen = ovCnt;
    convert(w);
    fork
      host.xfer(8, 1'b0, '0);
      begin
        repeat (60) @(posedge clk);
        #1 convertStartN = 1'b0;
        repeat (5) @(posedge clk);
        #1 convertStartN = 1'b1;
      end
    join
    check("during", expect_bits(prev, '0, 1'b0, 8), host.cap);
    wait_idle();
    repeat (20) @(posedge clk);
    #1;
    check("no restart", 1'b0, busy);
    check("no overrun", seen, ovCnt);
    convert(16'($urandom));
    host.xfer(18, 1'b0, '1);
    check("cut word", expect_bits(w, '1, 1'b0, 8), host.cap & 64'hFF);
    check("overrun", seen + 1, ovCnt);
    wait_idle();
    results();
  end

  initial
  begin
    #200us;
    num_errors++;
    results();
  end
endmodule
